// file: rtl/pmst_pkg.sv
// Package for the PMBus status byte bank: command codes, bit positions, carriers
package pmst_pkg;
    // Command codes of the three status bytes
    localparam logic [7:0] CMD_INPUT = 8'h7C;
    localparam logic [7:0] CMD_TEMP = 8'h7D;
    localparam logic [7:0] CMD_CML = 8'h7E;
    // Page values
    localparam logic [7:0] PAGE_A = 8'h00;
    localparam logic [7:0] PAGE_B = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hFF;
    // Supported-bit masks; all other bits read zero
    localparam logic [7:0] INPUT_MASK = 8'h9F;
    localparam logic [7:0] TEMP_MASK = 8'hC0;
    localparam logic [7:0] CML_MASK = 8'hEA;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Bit positions in the input status byte
    localparam int IN_OVF_BIT = 7;
    localparam int IN_UVF_BIT = 4;
    localparam int IN_LOW_BIT = 3;
    localparam int IN_OCF_BIT = 2;
    localparam int IN_OCW_BIT = 1;
    localparam int IN_OPW_BIT = 0;
    // Bit positions in the temperature status byte
    localparam int TMP_OT_FAULT_BIT = 7;
    localparam int TMP_OT_WARN_BIT = 6;
    // Bit positions in the communication status byte
    localparam int CML_CMD_BIT = 7;
    localparam int CML_DATA_BIT = 6;
    localparam int CML_PEC_BIT = 5;
    localparam int CML_MEM_BIT = 3;
    localparam int CML_COM_BIT = 1;

    // Input supply events, one-cycle or level, from the fault detectors
    typedef struct packed {
        logic input_overvoltage_fault;
        logic input_undervoltage_fault;
        logic unit_off_insufficient_input;
        logic input_overcurrent_fault;
        logic input_overcurrent_warning;
        logic input_overpower_warning;
    } pmst_input_ev_t;

    // Temperature events of one channel
    typedef struct packed {
        logic overtemperature_fault;
        logic overtemperature_warning;
    } pmst_temp_ev_t;

    // Communication, logic and memory events
    typedef struct packed {
        logic bad_command_flag;
        logic bad_payload_flag;
        logic packet_check_error_flag;
        logic memory_error_flag;
        logic other_comm_fault_flag;
    } pmst_cml_ev_t;

    // Byte access from the transaction engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] page;
    } pmst_req_t;
endpackage

// file: rtl/pmst_status_bank.sv
// PMBus input, temperature and communication status byte bank
`timescale 1ns/1ps
`default_nettype none
module pmst_status_bank (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire pmst_pkg::pmst_req_t req,
    input wire pmst_pkg::pmst_input_ev_t input_ev,
    input wire pmst_pkg::pmst_temp_ev_t temp_ev_a,
    input wire pmst_pkg::pmst_temp_ev_t temp_ev_b,
    input wire pmst_pkg::pmst_cml_ev_t cml_ev,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic cmd_hit
);
    import pmst_pkg::*;

    logic [7:0] supply_input_status_byte;
    logic [7:0] thermal_status_a;
    logic [7:0] thermal_status_b;
    logic [7:0] comm_logic_memory_status_byte;

    // Sticky update: set wins over clear, unsupported bits forced to zero
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                         input logic [7:0] clr, input logic [7:0] mask);
        sticky = ((cur & ~clr) | set) & mask;
    endfunction

    // Page decode; only the temperature byte looks at it
    wire page_b = (req.page == PAGE_B);
    wire hit_in = (req.cmd == CMD_INPUT);
    wire hit_tmp = (req.cmd == CMD_TEMP);
    wire hit_cml = (req.cmd == CMD_CML);
    wire wr_in = req.wr && hit_in;
    wire wr_tmp_a = req.wr && hit_tmp && !page_b;
    wire wr_tmp_b = req.wr && hit_tmp && page_b;
    wire wr_cml = req.wr && hit_cml;

    // Event vectors placed at their bit positions
    wire [7:0] set_in = {input_ev.input_overvoltage_fault, 2'b00,
                         input_ev.input_undervoltage_fault,
                         input_ev.unit_off_insufficient_input,
                         input_ev.input_overcurrent_fault,
                         input_ev.input_overcurrent_warning,
                         input_ev.input_overpower_warning};
    wire [7:0] set_ta = {temp_ev_a.overtemperature_fault, temp_ev_a.overtemperature_warning,
                         6'h00};
    wire [7:0] set_tb = {temp_ev_b.overtemperature_fault, temp_ev_b.overtemperature_warning,
                         6'h00};
    wire [7:0] set_cml = {cml_ev.bad_command_flag, cml_ev.bad_payload_flag,
                          cml_ev.packet_check_error_flag, 1'b0,
                          cml_ev.memory_error_flag, 1'b0,
                          cml_ev.other_comm_fault_flag, 1'b0};

    // Clear masks; a 0 written leaves a flag alone
    wire [7:0] clr_in = wr_in ? req.data : 8'h00;
    wire [7:0] clr_ta = wr_tmp_a ? req.data : 8'h00;
    wire [7:0] clr_tb = wr_tmp_b ? req.data : 8'h00;
    wire [7:0] clr_cml = wr_cml ? req.data : 8'h00;

    wire [7:0] next_input = sticky(supply_input_status_byte, set_in, clr_in, INPUT_MASK);
    wire [7:0] next_ta = sticky(thermal_status_a, set_ta, clr_ta, TEMP_MASK);
    wire [7:0] next_tb = sticky(thermal_status_b, set_tb, clr_tb, TEMP_MASK);
    wire [7:0] next_cml = sticky(comm_logic_memory_status_byte, set_cml, clr_cml, CML_MASK);

    // Read mux; page FFh or 00h both show channel A
    wire [7:0] thermal_status_byte = page_b ? thermal_status_b : thermal_status_a;
    wire [7:0] next_rd_data = hit_in ? supply_input_status_byte :
                              hit_tmp ? thermal_status_byte :
                              hit_cml ? comm_logic_memory_status_byte : 8'h00;

    // Bits that may read as one for the addressed byte; checked against the answer
    wire [7:0] rd_mask = hit_in ? INPUT_MASK :
                         hit_tmp ? TEMP_MASK :
                         hit_cml ? CML_MASK : 8'h00;

    // Status flags; a still-present condition sets again next cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_input_status_byte <= RESET_BYTE;
            thermal_status_a <= RESET_BYTE;
            thermal_status_b <= RESET_BYTE;
            comm_logic_memory_status_byte <= RESET_BYTE;
        end else begin
            supply_input_status_byte <= next_input;
            thermal_status_a <= next_ta;
            thermal_status_b <= next_tb;
            comm_logic_memory_status_byte <= next_cml;
        end
    end

    // Registered answer, one cycle after a read strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            cmd_hit <= 1'b0;
        end else begin
            rd_data <= req.rd ? next_rd_data : 8'h00;
            rd_valid <= req.rd;
            cmd_hit <= (req.rd || req.wr) && (hit_in || hit_tmp || hit_cml);
        end
    end

    property p_input_set;
        @(posedge mclk) disable iff (sys_rst)
        input_ev.input_overvoltage_fault |=> supply_input_status_byte[IN_OVF_BIT];
    endproperty
    a_input_set: assert property (p_input_set) else $error("input OV flag not set");

    property p_lowvin_hold;
        @(posedge mclk) disable iff (sys_rst)
        supply_input_status_byte[IN_LOW_BIT] && !(wr_in && req.data[IN_LOW_BIT])
            |=> supply_input_status_byte[IN_LOW_BIT];
    endproperty
    a_lowvin_hold: assert property (p_lowvin_hold) else $error("low input flag lost");

    property p_ocf_set;
        @(posedge mclk) disable iff (sys_rst)
        input_ev.input_overcurrent_fault && wr_in |=> supply_input_status_byte[IN_OCF_BIT];
    endproperty
    a_ocf_set: assert property (p_ocf_set) else $error("set lost against clear");

    property p_zero_bits;
        @(posedge mclk) disable iff (sys_rst)
        rd_valid |-> (rd_data & ~$past(rd_mask)) == 8'h00;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("reserved bit read as one");

    property p_clear_in;
        @(posedge mclk) disable iff (sys_rst)
        wr_in && req.data[IN_UVF_BIT] && !input_ev.input_undervoltage_fault
            |=> !supply_input_status_byte[IN_UVF_BIT];
    endproperty
    a_clear_in: assert property (p_clear_in) else $error("written one did not clear");

    property p_clear_cml;
        @(posedge mclk) disable iff (sys_rst)
        wr_cml && req.data[CML_PEC_BIT] && !cml_ev.packet_check_error_flag
            |=> !comm_logic_memory_status_byte[CML_PEC_BIT];
    endproperty
    a_clear_cml: assert property (p_clear_cml) else $error("comm flag not cleared");

    sequence s_read_temp_ffh;
        req.rd && hit_tmp && req.page == PAGE_ALL;
    endsequence
    property p_page_ff;
        @(posedge mclk) disable iff (sys_rst)
        s_read_temp_ffh |=> rd_data == $past(thermal_status_a);
    endproperty
    a_page_ff: assert property (p_page_ff) else $error("page FFh not channel A");

    property p_warn_b;
        @(posedge mclk) disable iff (sys_rst)
        temp_ev_b.overtemperature_warning |=> thermal_status_b[TMP_OT_WARN_BIT] ##1
            (thermal_status_b[TMP_OT_WARN_BIT] || $past(wr_tmp_b));
    endproperty
    a_warn_b: assert property (p_warn_b) else $error("channel B warning lost");

    property p_cml_shared;
        @(posedge mclk) disable iff (sys_rst)
        req.rd && hit_cml |=> rd_data == $past(comm_logic_memory_status_byte);
    endproperty
    a_cml_shared: assert property (p_cml_shared) else $error("comm read depends on page");

    property p_badcmd;
        @(posedge mclk) disable iff (sys_rst)
        cml_ev.bad_command_flag |=> comm_logic_memory_status_byte[CML_CMD_BIT];
    endproperty
    a_badcmd: assert property (p_badcmd) else $error("bad command not latched");

    property p_payload;
        @(posedge mclk) disable iff (sys_rst)
        cml_ev.bad_payload_flag ##1 !wr_cml |=> comm_logic_memory_status_byte[CML_DATA_BIT];
    endproperty
    a_payload: assert property (p_payload) else $error("bad data flag dropped");

    property p_mem;
        @(posedge mclk) disable iff (sys_rst)
        cml_ev.memory_error_flag |=> comm_logic_memory_status_byte[CML_MEM_BIT];
    endproperty
    a_mem: assert property (p_mem) else $error("memory error not latched");

    property p_pec_set;
        @(posedge mclk) disable iff (sys_rst)
        cml_ev.packet_check_error_flag |=> comm_logic_memory_status_byte[CML_PEC_BIT];
    endproperty
    a_pec_set: assert property (p_pec_set) else $error("check error not latched");

    property p_other_set;
        @(posedge mclk) disable iff (sys_rst)
        cml_ev.other_comm_fault_flag |=> comm_logic_memory_status_byte[CML_COM_BIT];
    endproperty
    a_other_set: assert property (p_other_set) else $error("other fault not latched");

    property p_input_shared;
        @(posedge mclk) disable iff (sys_rst)
        req.rd && hit_in |=> rd_data == $past(supply_input_status_byte);
    endproperty
    a_input_shared: assert property (p_input_shared) else $error("input read wrong");

    // Channel B is chosen only by page 01h
    sequence s_read_temp_b;
        req.rd && hit_tmp && page_b;
    endsequence
    property p_page_b;
        @(posedge mclk) disable iff (sys_rst)
        s_read_temp_b |=> rd_data == $past(thermal_status_b);
    endproperty
    a_page_b: assert property (p_page_b) else $error("page 01h not channel B");

    property p_clear_temp_a;
        @(posedge mclk) disable iff (sys_rst)
        wr_tmp_a && req.data[TMP_OT_FAULT_BIT] && !temp_ev_a.overtemperature_fault
            |=> !thermal_status_a[TMP_OT_FAULT_BIT];
    endproperty
    a_clear_temp_a: assert property (p_clear_temp_a) else $error("fault A not cleared");

    // No read strobe means a quiet answer the next cycle
    property p_idle_answer;
        @(posedge mclk) disable iff (sys_rst)
        !req.rd |=> !rd_valid && rd_data == 8'h00;
    endproperty
    a_idle_answer: assert property (p_idle_answer) else $error("answer without read");

    property p_write_hit;
        @(posedge mclk) disable iff (sys_rst)
        req.wr && hit_cml |=> cmd_hit && !rd_valid;
    endproperty
    a_write_hit: assert property (p_write_hit) else $error("write not acknowledged");
endmodule // pmst_status_bank
`default_nettype wire

// file: verification/pmst_host.sv
// Host model issuing single-byte status reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmst_host (
    input wire logic mclk,
    output var pmst_pkg::pmst_req_t req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_hit
);
    import pmst_pkg::*;
    initial req = '0;
    // Read Byte: strobe for one edge, take the answer just after that same edge
    task automatic read_byte(input logic [7:0] cmd, input logic [7:0] page,
        output logic [7:0] d, output logic v, output logic h);
        @(posedge mclk);
        #1;
        req = '{rd: 1'b1, wr: 1'b0, cmd: cmd, data: 8'h00, page: page};
        @(posedge mclk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, cmd: ~cmd, data: 8'hA5, page: ~page}; // Scrambled when idle
        d = rd_data;
        v = rd_valid;
        h = cmd_hit;
    endtask
    // Write Byte: one strobe, no answer awaited
    task automatic write_byte(input logic [7:0] cmd, input logic [7:0] page,
        input logic [7:0] data);
        @(posedge mclk);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, cmd: cmd, data: data, page: page};
        @(posedge mclk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, cmd: ~cmd, data: ~data, page: ~page};
    endtask
endmodule // pmst_host
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the status byte bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmst_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    pmst_req_t req;
    pmst_input_ev_t input_ev = '0;
    pmst_temp_ev_t temp_ev_a = '0;
    pmst_temp_ev_t temp_ev_b = '0;
    pmst_cml_ev_t cml_ev = '0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic cmd_hit;
    logic [7:0] m_in = 8'h00, m_ta = 8'h00, m_tb = 8'h00, m_cml = 8'h00;
    int n_fail = 0;
    int cmp_count = 0;
    always #5 mclk = ~mclk;
    pmst_status_bank dut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .input_ev(input_ev),
        .temp_ev_a(temp_ev_a), .temp_ev_b(temp_ev_b), .cml_ev(cml_ev),
        .rd_data(rd_data), .rd_valid(rd_valid), .cmd_hit(cmd_hit));
    pmst_host host (.mclk(mclk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd_hit(cmd_hit));
    // Expected answer; any page but B selects channel A
    function automatic logic [7:0] exp_rd(input logic [7:0] cmd, input logic [7:0] page);
        case (cmd)
            CMD_INPUT: return m_in;
            CMD_TEMP: return (page == PAGE_B) ? m_tb : m_ta;
            CMD_CML: return m_cml;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] rpage();
        logic [7:0] t[4] = '{PAGE_A, PAGE_B, PAGE_ALL, 8'(($urandom))};
        return t[$urandom_range(3)];
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // Read and compare data, valid and hit
    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] page);
        logic [7:0] d;
        logic v;
        logic h;
        host.read_byte(cmd, page, d, v, h);
        chk8(d, exp_rd(cmd, page));
        chk1(v, 1'b1);
        chk1(h, cmd inside {CMD_INPUT, CMD_TEMP, CMD_CML});
    endtask
    // Write and apply the clear mask to the model
    task automatic wr(input logic [7:0] cmd, input logic [7:0] page, input logic [7:0] d);
        host.write_byte(cmd, page, d);
        // A write to one of the three status commands answers with a hit pulse and no read data
        chk1(cmd_hit, cmd inside {CMD_INPUT, CMD_TEMP, CMD_CML});
        chk1(rd_valid, 1'b0);
        chk8(rd_data, 8'h00);
        if (cmd == CMD_INPUT) m_in &= ~(d & INPUT_MASK);
        if (cmd == CMD_TEMP && page == PAGE_B) m_tb &= ~(d & TEMP_MASK);
        if (cmd == CMD_TEMP && page != PAGE_B) m_ta &= ~(d & TEMP_MASK);
        if (cmd == CMD_CML) m_cml &= ~(d & CML_MASK);
    endtask
    // One-cycle event pulse; the model latches the mapped bits
    task automatic fire(input logic [5:0] i, input logic [1:0] a, input logic [1:0] b,
        input logic [4:0] c);
        @(posedge mclk);
        #1;
        {input_ev, temp_ev_a, temp_ev_b, cml_ev} = {i, a, b, c};
        m_in |= {i[5], 2'b00, i[4:0]};
        m_ta |= {a, 6'h00};
        m_tb |= {b, 6'h00};
        m_cml |= {c[4:2], 1'b0, c[1], 1'b0, c[0], 1'b0};
        @(posedge mclk);
        #1;
        {input_ev, temp_ev_a, temp_ev_b, cml_ev} = '0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        void'($urandom(32'hA6E5));
        repeat (6) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        for (int p = 0; p < 3; p++) begin
            rd_chk(CMD_INPUT, 8'(p));
            rd_chk(CMD_TEMP, 8'(p));
            rd_chk(CMD_CML, 8'(p));
        end
        $display("test reset done");
        // Each flag sets alone, then ones clear one position at a time
        for (int k = 0; k < 6; k++) begin
            fire(6'h01 << k, 2'b00, 2'b00, 5'h00);
            rd_chk(CMD_INPUT, rpage());
        end
        wr(CMD_INPUT, PAGE_B, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(CMD_INPUT, rpage(), 8'h01 << k);
            rd_chk(CMD_INPUT, PAGE_A);
        end
        // Event and clear in the same cycle: the set wins
        fire(6'h21, 2'b00, 2'b00, 5'h00);
        fork
            host.write_byte(CMD_INPUT, rpage(), 8'hFF);
            fire(6'h04, 2'b00, 2'b00, 5'h00);
        join
        m_in = 8'h04;
        rd_chk(CMD_INPUT, PAGE_A);
        $display("test input done");
        fire(6'h00, 2'b10, 2'b00, 5'h00);
        rd_chk(CMD_TEMP, PAGE_B);
        rd_chk(CMD_TEMP, PAGE_ALL);
        fire(6'h00, 2'b01, 2'b11, 5'h00);
        rd_chk(CMD_TEMP, PAGE_A);
        wr(CMD_TEMP, PAGE_B, 8'h3F);
        wr(CMD_TEMP, PAGE_B, 8'h80);
        rd_chk(CMD_TEMP, PAGE_B);
        rd_chk(CMD_TEMP, PAGE_A);
        // A clear at page FFh acts on channel A
        wr(CMD_TEMP, PAGE_ALL, 8'h80);
        rd_chk(CMD_TEMP, PAGE_A);
        rd_chk(CMD_TEMP, PAGE_B);
        $display("test temperature done");
        for (int k = 0; k < 5; k++) begin
            fire(6'h00, 2'b00, 2'b00, 5'h01 << k);
            rd_chk(CMD_CML, rpage());
        end
        for (int k = 0; k < 8; k++) begin
            wr(CMD_CML, rpage(), 8'h01 << k);
            rd_chk(CMD_CML, rpage());
        end
        rd_chk(8'h7B, PAGE_A);
        $display("test comm done");
        // Reset in mid-run wipes every flag and the answer
        fire(6'h3F, 2'b11, 2'b11, 5'h1F);
        @(posedge mclk);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        {m_in, m_ta, m_tb, m_cml} = '0;
        chk1(rd_valid, 1'b0);
        chk8(rd_data, 8'h00);
        rd_chk(CMD_INPUT, PAGE_A);
        rd_chk(CMD_TEMP, PAGE_B);
        rd_chk(CMD_TEMP, PAGE_A);
        rd_chk(CMD_CML, PAGE_B);
        $display("test mid reset done");
        // Random mix of events, writes and reads over 7Bh..7Fh
        for (int n = 0; n < 150; n++) begin
            case ($urandom_range(2))
                0: fire(6'($urandom), 2'($urandom), 2'($urandom), 5'($urandom));
                1: wr(8'h7B + 8'($urandom_range(4)), rpage(), 8'($urandom));
                default: rd_chk(8'h7B + 8'($urandom_range(4)), rpage());
            endcase
        end
        $display("test random done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
